// ### dv/vcm_color_stage_checker.sv
`timescale 1ns/100ps
module vcm_color_stage_checker #(
   parameter int DEPTH = 2
) (
   input wire logic coreClk,
   input wire logic reset_n,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid,
   input wire logic pixReady,
   input wire logic outValid,
   input wire logic outReady,
   input wire vcm_pkg::vcm_out_s outData,
   input wire logic uvSmoothEnable,
   input wire logic [2:0] chromaFilterSelect,
   input wire logic sincEnable,
   input wire vcm_pkg::vcm_pixel_s testPatternColor,
   input wire logic signed [7:0] hueOffset
);
   default clocking @(posedge coreClk); endclocking
   default disable iff (!reset_n);
   read_pulse_a: assert property (regRdValid == $past(regRdEn))
      else $error("read valid not one cycle after strobe");
   unmapped_zero_a: assert property (regRdEn && regAddr == 8'hFF |=> regRdData == 8'h00)
      else $error("unmapped read not zero");
   uv_smooth_a: assert property (
      regWrEn && regAddr == 8'h42 |=> uvSmoothEnable == $past(regWrData[0]))
      else $error("smoothing enable wrong");
   chroma_pick_a: assert property (uvSmoothEnable |-> chromaFilterSelect == 3'h7)
      else $error("chroma select wrong");
   sinc_enable_a: assert property (
      regWrEn && regAddr == 8'h13 |=> sincEnable == $past(regWrData[3]))
      else $error("sinc enable wrong");
   tp_colour_a: assert property (
      regWrEn && regAddr == 8'h17 |=> testPatternColor.cr == {$past(regWrData), 2'b00})
      else $error("pattern colour wrong");
   hue_offset_a: assert property (
      regWrEn && regAddr == 8'h60 |=> hueOffset == $past(regWrData) - 8'h80)
      else $error("hue offset wrong");
   out_hold_a: assert property (outValid && !outReady |=> outValid && $stable(outData))
      else $error("stalled output changed");
   full_nonempty_a: assert property (!pixReady |-> outValid)
      else $error("refusing while empty");
endmodule
bind vcm_color_stage vcm_color_stage_checker #(.DEPTH(DEPTH)) vcm_color_stage_checker_inst (
   .coreClk(coreClk), .reset_n(reset_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
   .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
   .pixReady(pixReady), .outValid(outValid), .outReady(outReady), .outData(outData),
   .uvSmoothEnable(uvSmoothEnable), .chromaFilterSelect(chromaFilterSelect),
   .sincEnable(sincEnable), .testPatternColor(testPatternColor), .hueOffset(hueOffset));

// ### dv/vcm_color_stage_tb.sv
`timescale 1ns/100ps
`define CHK(n, g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module vcm_color_stage_tb;
   logic coreClk, reset_n, regWrEn, regRdEn, pixValid, pixReady, outValid, outReady, srcEn;
   logic regRdValid, uvSmoothEnable, sincEnable, unsupportedConfig;
   logic [7:0] regAddr, regWrData, regRdData, w5, w3;
   logic [2:0] chromaFilterSelect;
   logic signed [7:0] hueOffset;
   logic [15:0] lfsr = 16'h5E34;
   logic [7:0] rst[7] = '{8'h03, 8'hF0, 8'h4E, 8'h0E, 8'h24, 8'h92, 8'h7C};
   logic [7:0] hv[3] = '{8'h00, 8'hFF, 8'h80};
   vcm_pkg::vcm_pixel_s pixIn, nextPix, testPatternColor;
   vcm_pkg::vcm_out_s outData;
   vcm_pkg::vcm_pixel_s q[$];
   int n_mismatch = 0, n_tests = 0, mode = 0;
   int gy = 32'h13B, gu = 32'h3B, gv = 32'h93, bu = 32'h248, rv = 32'h1F0;
   vcm_color_stage #(.DEPTH(2)) vcm_color_stage_inst (.coreClk(coreClk), .reset_n(reset_n),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
      .regRdData(regRdData), .regRdValid(regRdValid), .pixValid(pixValid), .pixReady(pixReady),
      .pixIn(pixIn), .pixSdPath(1'b0), .testPatternActive(1'b0), .vsyncPin(1'b0),
      .outValid(outValid), .outReady(outReady), .outData(outData),
      .uvSmoothEnable(uvSmoothEnable), .chromaFilterSelect(chromaFilterSelect),
      .sincEnable(sincEnable), .testPatternColor(testPatternColor), .hueOffset(hueOffset),
      .unsupportedConfig(unsupportedConfig));
   vcm_pix_source vcm_pix_source_inst (.clk(coreClk), .reset_n(reset_n), .enable(srcEn),
      .pixReady(pixReady), .nextPix(nextPix), .pixValid(pixValid), .pixIn(pixIn));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] rnd16();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction
   function automatic logic [9:0] clip(int v);
      return (v < 0) ? 10'h000 : (v > 1023) ? 10'h3FF : 10'(v);
   endfunction
   function automatic int rs(int v);
      return (v + 128) >>> 8;
   endfunction
   // Modes: 0 RGB (manual or automatic matrix), 1 manual YPrPb, 2 automatic YPrPb
   function automatic vcm_pkg::vcm_out_s expOut(vcm_pkg::vcm_pixel_s p);
      int y, b, r;
      y = int'(p.y) - 64;
      b = int'(p.cb) - 512;
      r = int'(p.cr) - 512;
      if (mode == 2) return {p.y, p.cb, p.cr};
      if (mode == 1) return {clip(rs(gy * y) + 64), clip(rs(bu * b) + 512), clip(rs(rv * r) + 512)};
      return {clip(rs(gy * y - gu * b - gv * r)), clip(rs(gy * y + bu * b)), clip(rs(gy * y + rv * r))};
   endfunction
   task stop_test();
      if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge coreClk);
      regWrEn = 1'b1;
      regAddr = a;
      regWrData = d;
      @(negedge coreClk);
      regWrEn = 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge coreClk);
      regRdEn = 1'b1;
      regAddr = a;
      @(negedge coreClk);
      regRdEn = 1'b0;
      `CHK("regRdValid", regRdValid, 1'b1)
      `CHK("regRdData", regRdData, e)
   endtask
   // Receiver stalls at random while the source streams
   task burst();
      srcEn = 1'b1;
      repeat (40) @(negedge coreClk) begin
         nextPix = 30'({rnd16(), rnd16()});
         outReady = ^rnd16();
      end
      srcEn = 1'b0;
      outReady = 1'b1;
      repeat (8) @(negedge coreClk);
      `CHK("drained", q.size(), 0)
   endtask
   always @(posedge coreClk) begin
      if (reset_n && pixValid && pixReady) q.push_back(pixIn);
      if (reset_n && outValid && outReady) `CHK("outData", outData, expOut(q.pop_front()))
   end
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      coreClk = 1'b0;
      forever #2 coreClk = ~coreClk;
   end
   initial begin
      #100000;
      n_mismatch++;
      stop_test();
   end
   initial begin
      {reset_n, regWrEn, regRdEn, regAddr, regWrData, srcEn, nextPix} = '0;
      outReady = 1'b1;
      repeat (2) @(negedge coreClk);
      reset_n = 1'b1;
      `CHK("outValid", outValid, 1'b0)
      `CHK("pixReady", pixReady, 1'b1)
      foreach (rst[i]) rd(8'(i + 3), rst[i]);
      rd(8'h02, 8'h00);
      rd(8'hFF, 8'h00);
      wr(8'h42, 8'h01);
      `CHK("uvSmoothEnable", uvSmoothEnable, 1'b1)
      `CHK("chromaFilterSelect", chromaFilterSelect, 3'h7)
      wr(8'h42, 8'h00);
      wr(8'h40, 8'hA0);
      `CHK("chromaFilterSelect", chromaFilterSelect, 3'h5)
      wr(8'h13, 8'h08);
      `CHK("sincEnable", sincEnable, 1'b1)
      w5 = rnd16();
      w3 = rnd16();
      wr(8'h16, w5);
      wr(8'h17, w3);
      wr(8'h18, 8'hF0);
      `CHK("testPatternColor", testPatternColor, {w5, 2'b00, 8'hF0, 2'b00, w3, 2'b00})
      hv[2] = w5;
      foreach (hv[i]) begin
         wr(8'h60, hv[i]);
         `CHK("hueOffset", hueOffset, 8'(hv[i] - 8'h80))
      end
      wr(8'h15, 8'h02);
      wr(8'h02, 8'h20);
      `CHK("unsupportedConfig", unsupportedConfig, 1'b1)
      wr(8'h15, 8'h00);
      `CHK("unsupportedConfig", unsupportedConfig, 1'b0)
      // manual matrix on for HDTV RGB
      wr(8'h02, 8'h08);
      burst();
      mode = 1;
      wr(8'h02, 8'h28);
      burst();
      wr(8'h05, w3);
      wr(8'h03, w5);
      gy = int'({w3, w5[1:0]});
      burst();
      mode = 2;
      wr(8'h02, 8'h20);
      burst();
      // Automatic RGB, SD/PS table, then HD table
      mode = 0;
      gy = vcm_pkg::AUTO_GY;
      gu = vcm_pkg::SDPS_GU;
      gv = vcm_pkg::SDPS_GV;
      bu = vcm_pkg::SDPS_BU;
      rv = vcm_pkg::SDPS_RV;
      wr(8'h02, 8'h00);
      burst();
      gu = vcm_pkg::HD_GU;
      gv = vcm_pkg::HD_GV;
      bu = vcm_pkg::HD_BU;
      rv = vcm_pkg::HD_RV;
      wr(8'h01, 8'h20);
      burst();
      stop_test();
   end
endmodule

// ### dv/vcm_pix_source.sv
`timescale 1ns/100ps
module vcm_pix_source (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic enable,
   input wire logic pixReady,
   input wire vcm_pkg::vcm_pixel_s nextPix,
   output logic pixValid,
   output vcm_pkg::vcm_pixel_s pixIn
);
   vcm_pkg::vcm_pixel_s data_reg;
   // Offer held until taken
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pixValid <= 1'b0;
      end else if (!pixValid || pixReady) begin
         pixValid <= enable;
         data_reg <= nextPix;
      end
   end
   // Idle bus shows the inverse, so a stale word never passes for data
   assign pixIn = pixValid ? data_reg : ~data_reg;
endmodule

// ### hw/vcm_color_stage.sv
`timescale 1ns/100ps
module vcm_color_stage #(
   parameter int DEPTH = 2
) (
   input wire logic coreClk,
   input wire logic reset_n,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   output logic regRdValid,
   input wire logic pixValid,
   output logic pixReady,
   input wire vcm_pkg::vcm_pixel_s pixIn,
   input wire logic pixSdPath,
   input wire logic testPatternActive,
   input wire logic vsyncPin,
   output logic outValid,
   input wire logic outReady,
   output vcm_pkg::vcm_out_s outData,
   output logic uvSmoothEnable,
   output logic [2:0] chromaFilterSelect,
   output logic sincEnable,
   output vcm_pkg::vcm_pixel_s testPatternColor,
   output logic signed [7:0] hueOffset,
   output logic unsupportedConfig
);
   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   logic [7:0] inModeReg, outModeReg, gyLowReg, rbLowReg, gyReg, guReg, gvReg;
   logic [7:0] buReg, rvReg, hdCtrlReg, hdFmtReg, tpYReg, tpCrReg, tpCbReg;
   logic [7:0] sdFiltReg, sdMode2Reg, sdMode8Reg, gainLowReg, gainYReg;
   logic [7:0] gainCbReg, gainCrReg, hueReg;

   always_ff @(posedge coreClk) begin
      if (!reset_n) begin
         gyLowReg <= vcm_pkg::RST_GY_LOW;
         rbLowReg <= vcm_pkg::RST_RB_LOW;
         gyReg <= vcm_pkg::RST_GY;
         guReg <= vcm_pkg::RST_GU;
         gvReg <= vcm_pkg::RST_GV;
         buReg <= vcm_pkg::RST_BU;
         rvReg <= vcm_pkg::RST_RV;
      end else if (regWrEn) begin
         if (regAddr == vcm_pkg::OFS_GY_LOW) begin
            gyLowReg <= regWrData;
         end else if (regAddr == vcm_pkg::OFS_RB_LOW) begin
            rbLowReg <= regWrData;
         end else if (regAddr == vcm_pkg::OFS_GY) begin
            gyReg <= regWrData;
         end else if (regAddr == vcm_pkg::OFS_GU) begin
            guReg <= regWrData;
         end else if (regAddr == vcm_pkg::OFS_GV) begin
            gvReg <= regWrData;
         end else if (regAddr == vcm_pkg::OFS_BU) begin
            buReg <= regWrData;
         end else if (regAddr == vcm_pkg::OFS_RV) begin
            rvReg <= regWrData;
         end
      end
   end

   always_ff @(posedge coreClk) begin
      if (!reset_n) begin
         inModeReg <= vcm_pkg::RST_ZERO;
         outModeReg <= vcm_pkg::RST_ZERO;
         hdCtrlReg <= vcm_pkg::RST_ZERO;
         hdFmtReg <= vcm_pkg::RST_ZERO;
         sdFiltReg <= vcm_pkg::RST_ZERO;
         sdMode2Reg <= vcm_pkg::RST_ZERO;
         sdMode8Reg <= vcm_pkg::RST_ZERO;
         tpYReg <= vcm_pkg::RST_TP_Y;
         tpCrReg <= vcm_pkg::RST_TP_C;
         tpCbReg <= vcm_pkg::RST_TP_C;
         hueReg <= vcm_pkg::RST_HUE;
      end else if (regWrEn) begin
         if (regAddr == vcm_pkg::OFS_INPUT_MODE) begin
            inModeReg <= regWrData;
         end else if (regAddr == vcm_pkg::OFS_OUTPUT_MODE) begin
            outModeReg <= regWrData;
         end else if (regAddr == vcm_pkg::OFS_HD_CTRL) begin
            hdCtrlReg <= regWrData;
         end else if (regAddr == vcm_pkg::OFS_HD_FORMAT) begin
            hdFmtReg <= regWrData;
         end else if (regAddr == vcm_pkg::OFS_SD_FILTER) begin
            sdFiltReg <= regWrData;
         end else if (regAddr == vcm_pkg::OFS_SD_MODE2) begin
            sdMode2Reg <= regWrData;
         end else if (regAddr == vcm_pkg::OFS_SD_MODE8) begin
            sdMode8Reg <= regWrData;
         end else if (regAddr == vcm_pkg::OFS_TP_Y) begin
            tpYReg <= regWrData;
         end else if (regAddr == vcm_pkg::OFS_TP_CR) begin
            tpCrReg <= regWrData;
         end else if (regAddr == vcm_pkg::OFS_TP_CB) begin
            tpCbReg <= regWrData;
         end else if (regAddr == vcm_pkg::OFS_HUE) begin
            hueReg <= regWrData;
         end
      end
   end

   always_ff @(posedge coreClk) begin
      if (!reset_n) begin
         gainLowReg <= vcm_pkg::RST_ZERO;
         gainYReg <= vcm_pkg::RST_GAIN;
         gainCbReg <= vcm_pkg::RST_GAIN;
         gainCrReg <= vcm_pkg::RST_GAIN;
      end else if (regWrEn) begin
         if (regAddr == vcm_pkg::OFS_SD_GAIN_LOW) begin
            gainLowReg <= regWrData;
         end else if (regAddr == vcm_pkg::OFS_SD_GAIN_Y) begin
            gainYReg <= regWrData;
         end else if (regAddr == vcm_pkg::OFS_SD_GAIN_CB) begin
            gainCbReg <= regWrData;
         end else if (regAddr == vcm_pkg::OFS_SD_GAIN_CR) begin
            gainCrReg <= regWrData;
         end
      end
   end

   // ------------------------------------------------------------
   // Register read-back
   // ------------------------------------------------------------
   logic [7:0] rdMux;
   always_comb begin
      if (regAddr == vcm_pkg::OFS_INPUT_MODE) rdMux = inModeReg;
      else if (regAddr == vcm_pkg::OFS_OUTPUT_MODE) rdMux = outModeReg;
      else if (regAddr == vcm_pkg::OFS_GY_LOW) rdMux = gyLowReg;
      else if (regAddr == vcm_pkg::OFS_RB_LOW) rdMux = rbLowReg;
      else if (regAddr == vcm_pkg::OFS_GY) rdMux = gyReg;
      else if (regAddr == vcm_pkg::OFS_GU) rdMux = guReg;
      else if (regAddr == vcm_pkg::OFS_GV) rdMux = gvReg;
      else if (regAddr == vcm_pkg::OFS_BU) rdMux = buReg;
      else if (regAddr == vcm_pkg::OFS_RV) rdMux = rvReg;
      else if (regAddr == vcm_pkg::OFS_HD_CTRL) rdMux = hdCtrlReg;
      else if (regAddr == vcm_pkg::OFS_HD_FORMAT) rdMux = hdFmtReg;
      else if (regAddr == vcm_pkg::OFS_TP_Y) rdMux = tpYReg;
      else if (regAddr == vcm_pkg::OFS_TP_CR) rdMux = tpCrReg;
      else if (regAddr == vcm_pkg::OFS_TP_CB) rdMux = tpCbReg;
      else if (regAddr == vcm_pkg::OFS_SD_FILTER) rdMux = sdFiltReg;
      else if (regAddr == vcm_pkg::OFS_SD_MODE2) rdMux = sdMode2Reg;
      else if (regAddr == vcm_pkg::OFS_SD_MODE8) rdMux = sdMode8Reg;
      else if (regAddr == vcm_pkg::OFS_SD_GAIN_LOW) rdMux = gainLowReg;
      else if (regAddr == vcm_pkg::OFS_SD_GAIN_Y) rdMux = gainYReg;
      else if (regAddr == vcm_pkg::OFS_SD_GAIN_CB) rdMux = gainCbReg;
      else if (regAddr == vcm_pkg::OFS_SD_GAIN_CR) rdMux = gainCrReg;
      else if (regAddr == vcm_pkg::OFS_HUE) rdMux = hueReg;
      else rdMux = 8'h00;
   end

   always_ff @(posedge coreClk) begin
      if (!reset_n) begin
         regRdData <= 8'h00;
         regRdValid <= 1'b0;
      end else begin
         regRdData <= regRdEn ? rdMux : 8'h00;
         regRdValid <= regRdEn;
      end
   end

   // ------------------------------------------------------------
   // Vsync pin synchroniser and SD gain double buffer
   // ------------------------------------------------------------
   logic [2:0] vsyncSync;
   always_ff @(posedge coreClk) begin
      if (!reset_n) vsyncSync <= 3'h0;
      else vsyncSync <= {vsyncSync[1:0], vsyncPin};
   end
   // Stage 0 feeds stage 1 only; the edge is judged on stages 1 and 2
   logic vsyncFall;
   assign vsyncFall = vsyncSync[2] && !vsyncSync[1];

   // Low bits packed Y, Cb, Cr
   logic [9:0] gainYNew, gainCbNew, gainCrNew;
   assign gainYNew = {gainYReg, gainLowReg[1:0]};
   assign gainCbNew = {gainCbReg, gainLowReg[3:2]};
   assign gainCrNew = {gainCrReg, gainLowReg[5:4]};

   logic [9:0] gainYAct, gainCbAct, gainCrAct;
   always_ff @(posedge coreClk) begin
      if (!reset_n) begin
         gainYAct <= {vcm_pkg::RST_GAIN, 2'b00};
         gainCbAct <= {vcm_pkg::RST_GAIN, 2'b00};
         gainCrAct <= {vcm_pkg::RST_GAIN, 2'b00};
      end else if (!sdMode8Reg[vcm_pkg::BIT_SD_DBLBUF] || vsyncFall) begin
         gainYAct <= gainYNew;
         gainCbAct <= gainCbNew;
         gainCrAct <= gainCrNew;
      end
   end

   // ------------------------------------------------------------
   // Filter and hue controls
   // ------------------------------------------------------------
   // UV smoothing enable
   assign uvSmoothEnable = sdMode2Reg[vcm_pkg::BIT_UV_SMOOTH];
   assign chromaFilterSelect = uvSmoothEnable ? vcm_pkg::CHROMA_SEL_UV_SMOOTH
                                              : sdFiltReg[7:5];
   assign sincEnable = hdCtrlReg[vcm_pkg::BIT_SINC];
   assign testPatternColor = '{y: {tpYReg, 2'b00}, cb: {tpCbReg, 2'b00},
                               cr: {tpCrReg, 2'b00}};
   assign hueOffset = $signed(hueReg ^ vcm_pkg::RST_HUE);

   // ------------------------------------------------------------
   // Arithmetic helpers
   // ------------------------------------------------------------
   // Round and clamp
   function automatic logic [9:0] clampScale(input logic signed [23:0] prod,
                                              input int shift,
                                              input logic signed [11:0] base);
      logic signed [23:0] v;
      v = (prod + (24'sd1 <<< (shift - 1))) >>> shift;
      v = v + base;
      if (v < 0) return 10'h000;
      else if (v > $signed({14'h0, vcm_pkg::CODE_MAX})) return vcm_pkg::CODE_MAX;
      else return v[9:0];
   endfunction

   function automatic logic signed [23:0] mul(input logic [9:0] c,
                                              input logic signed [11:0] x);
      logic signed [11:0] cs;
      cs = $signed({2'b00, c});
      return 24'(cs * x);
   endfunction

   // ------------------------------------------------------------
   // Colour datapath
   // ------------------------------------------------------------
   logic rgbIn, outYPrPb, manualOn, isHdMode;
   assign outYPrPb = outModeReg[vcm_pkg::BIT_OUT_YPRPB];
   // Input format bit ignored on SD
   assign rgbIn = hdFmtReg[vcm_pkg::BIT_RGB_IN] && !pixSdPath && !testPatternActive;
   assign manualOn = outModeReg[vcm_pkg::BIT_MANUAL] && !pixSdPath && !testPatternActive;
   assign isHdMode = (inModeReg[6:4] == vcm_pkg::INMODE_HD);
   // RGB in with YPrPb out is not converted
   assign unsupportedConfig = hdFmtReg[vcm_pkg::BIT_RGB_IN] && outYPrPb;

   logic [9:0] cGy, cGu, cGv, cBu, cRv;
   always_comb begin
      if (manualOn) begin
         cGy = {gyReg, gyLowReg[1:0]};
         cGu = {guReg, rbLowReg[5:4]};
         cGv = {gvReg, rbLowReg[7:6]};
         cBu = {buReg, rbLowReg[3:2]};
         cRv = {rvReg, rbLowReg[1:0]};
      end else if (isHdMode && !pixSdPath) begin
         cGy = vcm_pkg::AUTO_GY;
         cGu = vcm_pkg::HD_GU;
         cGv = vcm_pkg::HD_GV;
         cBu = vcm_pkg::HD_BU;
         cRv = vcm_pkg::HD_RV;
      end else begin
         cGy = vcm_pkg::AUTO_GY;
         cGu = vcm_pkg::SDPS_GU;
         cGv = vcm_pkg::SDPS_GV;
         cBu = vcm_pkg::SDPS_BU;
         cRv = vcm_pkg::SDPS_RV;
      end
   end

   vcm_pkg::vcm_pixel_s srcPix, gainPix;
   assign srcPix = testPatternActive ? testPatternColor : pixIn;

   // SD gain on SD-path pixels only (pixSdPath), not on HD/PS-path pixels
   always_comb begin
      if (pixSdPath) begin
         gainPix.y = clampScale(mul(gainYAct, $signed({2'b00, srcPix.y}) -
                                vcm_pkg::LUMA_BLACK), vcm_pkg::GAIN_SHIFT,
                                vcm_pkg::LUMA_BLACK);
         gainPix.cb = clampScale(mul(gainCbAct, $signed({2'b00, srcPix.cb}) -
                                 vcm_pkg::CHROMA_ZERO), vcm_pkg::GAIN_SHIFT,
                                 vcm_pkg::CHROMA_ZERO);
         gainPix.cr = clampScale(mul(gainCrAct, $signed({2'b00, srcPix.cr}) -
                                 vcm_pkg::CHROMA_ZERO), vcm_pkg::GAIN_SHIFT,
                                 vcm_pkg::CHROMA_ZERO);
      end else begin
         gainPix = srcPix;
      end
   end

   logic signed [11:0] yOfs, pbOfs, prOfs;
   logic signed [23:0] tY, tGu, tGv;
   vcm_pkg::vcm_out_s mtx;
   assign yOfs = $signed({2'b00, gainPix.y}) - vcm_pkg::LUMA_BLACK;
   assign pbOfs = $signed({2'b00, gainPix.cb}) - vcm_pkg::CHROMA_ZERO;
   assign prOfs = $signed({2'b00, gainPix.cr}) - vcm_pkg::CHROMA_ZERO;
   assign tY = mul(cGy, yOfs);
   // Green cross coefficients are stored as magnitudes and subtracted
   assign tGu = mul(cGu, pbOfs);
   assign tGv = mul(cGv, prOfs);

   always_comb begin
      if (rgbIn) begin
         // RGB arrives as G, B, R and passes untouched
         mtx = '{gY: gainPix.y, bPb: gainPix.cb, rPr: gainPix.cr};
      end else if (outYPrPb && !manualOn) begin
         mtx = '{gY: gainPix.y, bPb: gainPix.cb, rPr: gainPix.cr};
      end else if (outYPrPb) begin
         mtx.gY = clampScale(tY, vcm_pkg::COEF_SHIFT, vcm_pkg::LUMA_BLACK);
         mtx.bPb = clampScale(mul(cBu, pbOfs), vcm_pkg::COEF_SHIFT,
                              vcm_pkg::CHROMA_ZERO);
         mtx.rPr = clampScale(mul(cRv, prOfs), vcm_pkg::COEF_SHIFT,
                              vcm_pkg::CHROMA_ZERO);
      end else begin
         mtx.gY = clampScale(tY - tGu - tGv, vcm_pkg::COEF_SHIFT, 12'sh000);
         mtx.bPb = clampScale(tY + mul(cBu, pbOfs), vcm_pkg::COEF_SHIFT, 12'sh000);
         mtx.rPr = clampScale(tY + mul(cRv, prOfs), vcm_pkg::COEF_SHIFT, 12'sh000);
      end
   end

   // ------------------------------------------------------------
   // Output buffer
   // ------------------------------------------------------------
   // Absorbs a receiver stall without losing the word in flight
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   vcm_pkg::vcm_out_s bufMem [DEPTH];
   logic [PTR_W-1:0] wrPtr, rdPtr;
   logic [PTR_W:0] count;
   logic doWr, doRd;
   assign pixReady = (count != (PTR_W + 1)'(DEPTH));
   assign outValid = (count != '0);
   assign doWr = pixValid && pixReady;
   assign doRd = outValid && outReady;
   assign outData = bufMem[rdPtr];

   always_ff @(posedge coreClk) begin
      if (doWr) bufMem[wrPtr] <= mtx;
   end

   always_ff @(posedge coreClk) begin
      if (!reset_n) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (doWr) wrPtr <= (wrPtr == PTR_W'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
         if (doRd) rdPtr <= (rdPtr == PTR_W'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
         if (doWr && !doRd) count <= count + 1'b1;
         else if (doRd && !doWr) count <= count - 1'b1;
      end
   end
endmodule

// ### shared/vcm_pkg.sv
// Contract
// - UV smoothing filter on U/V outputs, ~2.7 MHz, enabled by 0x42 bit 0.
// - With UV smoothing off, the programmed chroma low-pass filter is used.
// - Sinc compensation on the PS/HD path, enabled by 0x13 bit 3.
// - Registers 0x16-0x18 colour the HD test pattern only, not external pixels.
// - Automatic matrix scaling follows input mode field 0x01 bits 6:4.
// - No RGB-in to YPrPb-out conversion, no SD RGB input.
// - 0x02 bit 5: 1 YPrPb out, 0 RGB; 0x15 bit 1: RGB in (PS/HD).
// - Manual matrix via 0x02 bit 3, off after reset, PS/HD only.
// - Preset coefficients 0x13B, 0x3B, 0x93, 0x248, 0x1F0 give HDTV colour.
// - Manual matrix acts on external HD/PS data, not during test patterns.
// - Coefficients are 10 bits: upper byte plus two low bits in matrix_green_luma_low_bits/matrix_red_blue_low_bits.
// - RGB out: G = luma term minus cross terms; B and R add one term.
// - Manual YPrPb out: Y, Pb, Pr each scaled by own coefficient, no cross terms; automatic YPrPb passes through.
// - Matrix registers matrix_green_luma_low_bits-0x09 reset to 03, F0, 4E, 0E, 24, 92, 7C.
// - SD Y/Cb/Cr gains are 10 bits, factor times 512.
// - SD gains: low bits in 0x5C, upper bytes at 0x5D/0x5E/0x5F.
// - SD gain scaling acts on every interlaced output format; the code scales only SD-path pixels (pixSdPath), never HD-path ones.
// - Hue register 0x60 shifts subcarrier phase per step about centre 0x80.
// - SD gain writes take effect on falling vsync when double buffered.
package vcm_pkg;
   typedef struct packed {
      logic [9:0] y;
      logic [9:0] cb;
      logic [9:0] cr;
   } vcm_pixel_s;
   typedef struct packed {
      logic [9:0] gY;
      logic [9:0] bPb;
      logic [9:0] rPr;
   } vcm_out_s;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_INPUT_MODE = 8'h01;
   localparam logic [7:0] OFS_OUTPUT_MODE = 8'h02;
   localparam logic [7:0] OFS_GY_LOW = 8'h03;
   localparam logic [7:0] OFS_RB_LOW = 8'h04;
   localparam logic [7:0] OFS_GY = 8'h05;
   localparam logic [7:0] OFS_GU = 8'h06;
   localparam logic [7:0] OFS_GV = 8'h07;
   localparam logic [7:0] OFS_BU = 8'h08;
   localparam logic [7:0] OFS_RV = 8'h09;
   localparam logic [7:0] OFS_HD_CTRL = 8'h13;
   localparam logic [7:0] OFS_HD_FORMAT = 8'h15;
   localparam logic [7:0] OFS_TP_Y = 8'h16;
   localparam logic [7:0] OFS_TP_CR = 8'h17;
   localparam logic [7:0] OFS_TP_CB = 8'h18;
   localparam logic [7:0] OFS_SD_FILTER = 8'h40;
   localparam logic [7:0] OFS_SD_MODE2 = 8'h42;
   localparam logic [7:0] OFS_SD_MODE8 = 8'h48;
   localparam logic [7:0] OFS_SD_GAIN_LOW = 8'h5C;
   localparam logic [7:0] OFS_SD_GAIN_Y = 8'h5D;
   localparam logic [7:0] OFS_SD_GAIN_CB = 8'h5E;
   localparam logic [7:0] OFS_SD_GAIN_CR = 8'h5F;
   localparam logic [7:0] OFS_HUE = 8'h60;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_GY_LOW = 8'h03;
   localparam logic [7:0] RST_RB_LOW = 8'hF0;
   localparam logic [7:0] RST_GY = 8'h4E;
   localparam logic [7:0] RST_GU = 8'h0E;
   localparam logic [7:0] RST_GV = 8'h24;
   localparam logic [7:0] RST_BU = 8'h92;
   localparam logic [7:0] RST_RV = 8'h7C;
   localparam logic [7:0] RST_TP_Y = 8'h10;
   localparam logic [7:0] RST_TP_C = 8'h80;
   localparam logic [7:0] RST_GAIN = 8'h80;
   localparam logic [7:0] RST_HUE = 8'h80;
   // ------------------------------------------------------------
   // Field positions and codes
   // ------------------------------------------------------------
   localparam int BIT_MANUAL = 3;
   localparam int BIT_OUT_YPRPB = 5;
   localparam int BIT_SINC = 3;
   localparam int BIT_RGB_IN = 1;
   localparam int BIT_UV_SMOOTH = 0;
   localparam int BIT_SD_DBLBUF = 2;
   localparam logic [2:0] INMODE_HD = 3'h2;
   localparam logic [2:0] CHROMA_SEL_UV_SMOOTH = 3'h7;
   // ------------------------------------------------------------
   // Arithmetic constants
   // ------------------------------------------------------------
   localparam int COEF_SHIFT = 8;
   localparam int GAIN_SHIFT = 9;
   localparam logic signed [11:0] LUMA_BLACK = 12'sh040;
   localparam logic signed [11:0] CHROMA_ZERO = 12'sh200;
   localparam logic [9:0] CODE_MAX = 10'h3FF;
   localparam logic [9:0] AUTO_UNITY = 10'h100;
   localparam logic [9:0] AUTO_GY = 10'h12A;
   localparam logic [9:0] SDPS_GU = 10'h067;
   localparam logic [9:0] SDPS_GV = 10'h0D5;
   localparam logic [9:0] SDPS_BU = 10'h210;
   localparam logic [9:0] SDPS_RV = 10'h1A2;
   localparam logic [9:0] HD_GU = 10'h038;
   localparam logic [9:0] HD_GV = 10'h08B;
   localparam logic [9:0] HD_BU = 10'h229;
   localparam logic [9:0] HD_RV = 10'h1D5;
endpackage
